/* File: dv/icrl_bus_partner.sv */
// another master on the two-wire bus, open-drain outputs
// assumes bench pull-ups resolve both lines; 80 ns bit period
`timescale 1ns/1ps
`default_nettype none
module icrl_bus_partner (
    output logic scl_o,
    output logic sda_o,
    input wire logic scl_line,
    input wire logic sda_line
);
    int stalls = 0;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // keep line changes off the system clock edges
    task automatic align();
        while (($time % 10) != 2) #1;
    endtask : align
    // high phase starts once any stretch has ended, or after 2000 polls of 10 ns
    task automatic rise_scl();
        int n;
        n = 0;
        scl_o = 1'b1;
        while (scl_line !== 1'b1 && n < 2000) begin
            #10;
            n++;
        end
        if (n == 2000) stalls++;
        #30;
    endtask : rise_scl
    task automatic start_cond();
        align();
        sda_o = 1'b1;
        rise_scl();
        sda_o = 1'b0;
        #30;
        scl_o = 1'b0;
        #40;
    endtask : start_cond
    task automatic send_byte(input logic [7:0] b, output logic ack);
        align();
        for (int i = 7; i >= 0; i--) begin
            sda_o = b[i];
            #10;
            rise_scl();
            scl_o = 1'b0;
            #40;
        end
        sda_o = 1'b1;
        #10;
        rise_scl();
        ack = (sda_line === 1'b0);
        scl_o = 1'b0;
        #40;
    endtask : send_byte
    // master read of one byte; give_ack low answers not-acknowledge
    task automatic recv_byte(input logic give_ack, output logic [7:0] b);
        align();
        sda_o = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            #10;
            rise_scl();
            b[i] = sda_line;
            scl_o = 1'b0;
            #40;
        end
        sda_o = !give_ack;
        #10;
        rise_scl();
        scl_o = 1'b0;
        #40;
        sda_o = 1'b1;
    endtask : recv_byte
    task automatic stop_cond();
        align();
        sda_o = 1'b0;
        #10;
        rise_scl();
        sda_o = 1'b1;
        #40;
    endtask : stop_cond
endmodule : icrl_bus_partner
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench of the serial bus control block
// assumes icrl_core and icrl_bus_partner; pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
module tb;
    import icrl_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic idle_mode = 1'b0;
    icrl_bus_req_type bus_req = '0;
    icrl_pin_type port_scl = '{1'b1, 1'b1};
    icrl_pin_type port_sda = '{1'b1, 1'b1};
    icrl_pin_type scl_pin;
    icrl_pin_type sda_pin;
    logic [15:0] bus_rdata;
    logic [GO_W-1:0] master_go;
    logic slew_off;
    logic smbus_levels;
    logic irq;
    logic scl_m;
    logic sda_m;
    logic scl_line;
    logic sda_line;
    logic ack;
    logic [15:0] rd_v;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    assign scl_line = scl_m & (scl_pin.oe_n | scl_pin.out);
    assign sda_line = sda_m & (sda_pin.oe_n | sda_pin.out);
    always #5 clock = ~clock;
    icrl_core dut (.clock(clock), .rst(rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .idle_mode(idle_mode), .scl_in(scl_line),
        .sda_in(sda_line), .port_scl(port_scl), .port_sda(port_sda),
        .scl_pin(scl_pin), .sda_pin(sda_pin), .master_go(master_go),
        .slew_off(slew_off), .smbus_levels(smbus_levels), .irq(irq));
    icrl_bus_partner link (.scl_o(scl_m), .sda_o(sda_m),
        .scl_line(scl_line), .sda_line(sda_line));
    task automatic wrap_up();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clock);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus_req.wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clock);
        bus_req.rd <= 1'b0;
        #1;
        rd_v = bus_rdata;
    endtask : rd_reg
    // address phase, second byte only for a matched wide prefix
    task automatic probe(input logic [15:0] ctl, input logic [7:0] b1,
                         input logic [7:0] b2, input logic exp);
        wr_reg(ADDR_CONTROL, ctl);
        link.start_cond();
        link.send_byte(b1, ack);
        if (ack && ctl[B_WIDE] && b1[7:3] == WIDE_PREFIX) begin
            wr_reg(ADDR_CONTROL, ctl);
            link.send_byte(b2, ack);
        end
        chk("address ack", {15'h0, exp}, {15'h0, ack});
        if (ack) wr_reg(ADDR_CONTROL, ctl);
        link.stop_cond();
        rd_reg(ADDR_STATUS);
        wr_reg(ADDR_CLEAR, 16'h001f);
    endtask : probe
    task automatic t_reset();
        rd_reg(ADDR_CONTROL);
        chk("control reset", CONTROL_RESET, rd_v);
        chk("irq reset", 16'h0, {15'h0, irq});
        @(posedge clock);
        port_scl <= '{1'b0, 1'b0};
        @(posedge clock);
        #1;
        chk("pin from port", {14'h0, port_scl}, {14'h0, scl_pin});
        @(posedge clock);
        port_scl <= '{1'b1, 1'b1};
    endtask : t_reset
    task automatic t_regs();
        int n;
        n = 0;
        wr_reg(ADDR_CONTROL, 16'h431f);
        repeat (3) begin
            #1;
            if (master_go === 5'h1f) n++;
            @(posedge clock);
        end
        chk("master go pulse", 16'h1, n[15:0]);
        chk("pad levels", 16'h3, {14'h0, slew_off, smbus_levels});
        rd_reg(ADDR_CONTROL);
        chk("release kept", 16'h1300, rd_v);
        wr_reg(ADDR_CONTROL, 16'h1040);
        wr_reg(ADDR_CONTROL, 16'h0040);
        rd_reg(ADDR_CONTROL);
        chk("release zero", 16'h0040, rd_v);
        wr_reg(ADDR_STATUS, 16'h001f);
        rd_reg(ADDR_STATUS);
        chk("status read only", 16'h0, rd_v);
        for (int a = 3; a < 8; a += 4) begin
            wr_reg(a[ADDR_W-1:0], 16'h001f);
            rd_reg(a[ADDR_W-1:0]);
            chk("clear and unmapped", 16'h0, rd_v);
        end
    endtask : t_regs
    task automatic t_write();
        wr_reg(ADDR_SLAVE, 16'h0052);
        wr_reg(ADDR_ENABLE, 16'h001f);
        wr_reg(ADDR_CONTROL, 16'h9040);
        link.start_cond();
        link.send_byte(8'ha4, ack);
        chk("address ack", 16'h1, {15'h0, ack});
        repeat (20) @(posedge clock);
        #1;
        chk("clock held", 16'h0, {15'h0, scl_pin.oe_n});
        chk("irq on address", 16'h1, {15'h0, irq});
        rd_reg(ADDR_CONTROL);
        chk("release cleared", 16'h8040, rd_v);
        wr_reg(ADDR_ENABLE, 16'h0000);
        @(posedge clock);
        #1;
        chk("irq masked", 16'h0, {15'h0, irq});
        wr_reg(ADDR_ENABLE, 16'h001f);
        wr_reg(ADDR_CONTROL, 16'h9040);
        @(posedge clock);
        #1;
        chk("clock freed", 16'h1, {15'h0, scl_pin.oe_n});
        link.send_byte(8'h3c, ack);
        chk("data ack", 16'h1, {15'h0, ack});
        repeat (10) @(posedge clock);
        #1;
        chk("held after data", 16'h0, {15'h0, scl_pin.oe_n});
        rd_reg(ADDR_RXDATA);
        chk("rx data", 16'h003c, rd_v);
        rd_reg(ADDR_STATUS);
        chk("status after byte", 16'h0003, rd_v);
        wr_reg(ADDR_CONTROL, 16'h9040);
        link.stop_cond();
        rd_reg(ADDR_STATUS);
        chk("status after stop", 16'h0013, rd_v);
        wr_reg(ADDR_CLEAR, 16'h001f);
        rd_reg(ADDR_STATUS);
        chk("status cleared", 16'h0, rd_v);
        chk("irq cleared", 16'h0, {15'h0, irq});
    endtask : t_write
    task automatic t_modes();
        probe(16'h9000, 8'h10, 8'h00, 1'b0);
        probe(16'h9800, 8'h10, 8'h00, 1'b1);
        probe(16'h9000, 8'h00, 8'h00, 1'b0);
        probe(16'h9080, 8'h00, 8'h00, 1'b1);
        chk("general call", 16'h1, {15'h0, rd_v[EV_GCALL]});
        wr_reg(ADDR_SLAVE, 16'h02a5);
        rd_reg(ADDR_SLAVE);
        chk("slave address", 16'h02a5, rd_v);
        probe(16'h9400, 8'hf4, 8'ha5, 1'b1);
        probe(16'h9400, 8'hf4, 8'ha4, 1'b0);
        probe(16'h9000, 8'hf4, 8'h00, 1'b0);
        probe(16'h9000, 8'h4a, 8'h00, 1'b1);
        @(posedge clock);
        idle_mode <= 1'b1;
        probe(16'hb000, 8'h4a, 8'h00, 1'b0);
        probe(16'h9000, 8'h4a, 8'h00, 1'b1);
        @(posedge clock);
        idle_mode <= 1'b0;
        probe(16'h1000, 8'h4a, 8'h00, 1'b0);
    endtask : t_modes
    task automatic t_read();
        logic [7:0] got;
        wr_reg(ADDR_TXDATA, 16'h00a6);
        rd_reg(ADDR_TXDATA);
        chk("tx data reg", 16'h00a6, rd_v);
        wr_reg(ADDR_CONTROL, 16'h9000);
        link.start_cond();
        link.send_byte(8'h4b, ack);
        chk("read address ack", 16'h1, {15'h0, ack});
        repeat (4) @(posedge clock);
        #1;
        chk("held before send", 16'h0, {15'h0, scl_pin.oe_n});
        wr_reg(ADDR_CONTROL, 16'h9000);
        link.recv_byte(1'b0, got);
        chk("byte sent", 16'h00a6, {8'h00, got});
        link.stop_cond();
        rd_reg(ADDR_STATUS);
        chk("status after read", 16'h0015, rd_v);
        wr_reg(ADDR_CLEAR, 16'h001f);
    endtask : t_read
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_write();
        t_modes();
        t_read();
        chk("bus stalls", 16'h0, 16'(link.stalls));
        wrap_up();
    end
endmodule : tb
`default_nettype wire

/* File: hdl/icrl_core.sv */
// control register and slave engine of the two-wire serial bus block
// assumes open-drain pins resolved outside; port logic owns pins when off
`timescale 1ns/1ps
`default_nettype none
module icrl_core (
    input wire logic clock,
    input wire logic rst,
    input wire icrl_pkg::icrl_bus_req_type bus_req,
    output logic [15:0] bus_rdata,
    input wire logic idle_mode,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire icrl_pkg::icrl_pin_type port_scl,
    input wire icrl_pkg::icrl_pin_type port_sda,
    output icrl_pkg::icrl_pin_type scl_pin,
    output icrl_pkg::icrl_pin_type sda_pin,
    output logic [icrl_pkg::GO_W-1:0] master_go,
    output logic slew_off,
    output logic smbus_levels,
    output logic irq
);
    import icrl_pkg::*;

    typedef struct packed {
        logic [15:0] control;
        logic [SADDR_W-1:0] slave_addr;
        logic [NUM_EVENTS-1:0] status;
        logic [NUM_EVENTS-1:0] enable;
        logic [7:0] rx_data;
        logic [7:0] tx_data;
        logic [15:0] rdata;
        logic [GO_W-1:0] go;
        icrl_state_type state;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic scl_prev;
        logic sda_prev;
        logic sda_hold;
        logic reading;
        logic wide_seen;
        logic acked;
    } icrl_core_state_type;

    icrl_core_state_type q;
    icrl_core_state_type n;
    logic scl_s;
    logic sda_s;
    logic run;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic busy;
    logic gc_hit;
    logic addr_hit;
    logic [NUM_EVENTS-1:0] ev;

    // first address byte match for 7-bit or 10-bit addressing
    function automatic logic first_byte_hit(input logic [7:0] b,
        input logic [SADDR_W-1:0] sa, input logic wide,
        input logic wide_seen);
        if (wide) begin
            first_byte_hit = (b[7:3] == WIDE_PREFIX) && (b[2:1] == sa[9:8])
                && (!b[0] || wide_seen);
        end else begin
            first_byte_hit = (b[7:1] == sa[6:0]);
        end
    endfunction : first_byte_hit

    icrl_sync #(
        .WIDTH(2)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({scl_in, sda_in}),
        .sync_out({scl_s, sda_s})
    );

    assign run = q.control[B_MODULE_ON]
        && !(q.control[B_IDLE_HALT] && idle_mode);
    assign scl_rise = scl_s && !q.scl_prev;
    assign scl_fall = !scl_s && q.scl_prev;
    assign start_seen = scl_s && q.scl_prev && q.sda_prev && !sda_s;
    assign stop_seen = scl_s && q.scl_prev && !q.sda_prev && sda_s;
    assign busy = (q.state != S_IDLE) && (q.state != S_WAIT_STOP);
    assign gc_hit = q.control[B_GC_EN] && (q.shift == GCALL_ADDR);
    assign addr_hit = q.control[B_ACCEPT_ALL] || gc_hit
        || first_byte_hit(q.shift, q.slave_addr, q.control[B_WIDE],
        q.wide_seen);

    always_comb begin
        n = q;
        ev = '0;
        n.scl_prev = scl_s;
        n.sda_prev = sda_s;
        n.go = '0;
        n.control = q.control & ~MASTER_GO_MASK;
        n.rdata = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_CONTROL: n.rdata = q.control;
                ADDR_SLAVE: n.rdata = {6'h00, q.slave_addr};
                ADDR_STATUS: n.rdata = {11'h000, q.status};
                ADDR_ENABLE: n.rdata = {11'h000, q.enable};
                ADDR_RXDATA: n.rdata = {8'h00, q.rx_data};
                ADDR_TXDATA: n.rdata = {8'h00, q.tx_data};
                default: n.rdata = '0;
            endcase
        end
        if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_CONTROL: begin
                    n.control = bus_req.wdata & CONTROL_WMASK;
                    n.go = bus_req.wdata[GO_W-1:0];
                    if (!q.control[B_STRETCH]
                        && !bus_req.wdata[B_CLK_REL]) begin
                        n.control[B_CLK_REL] = q.control[B_CLK_REL];
                    end
                end
                ADDR_SLAVE: n.slave_addr = bus_req.wdata[SADDR_W-1:0];
                ADDR_CLEAR: n.status = q.status
                    & ~bus_req.wdata[NUM_EVENTS-1:0];
                ADDR_ENABLE: n.enable = bus_req.wdata[NUM_EVENTS-1:0];
                ADDR_TXDATA: n.tx_data = bus_req.wdata[7:0];
                default: n.tx_data = q.tx_data;
            endcase
        end
        if (!run) begin
            n.state = S_IDLE;
            n.sda_hold = 1'b0;
            n.wide_seen = 1'b0;
        end else if (stop_seen) begin
            if (q.state != S_IDLE) begin
                ev[EV_STOP] = 1'b1;
            end
            n.state = S_IDLE;
            n.sda_hold = 1'b0;
            n.wide_seen = 1'b0;
        end else if (start_seen) begin
            n.state = S_ADDR;
            n.cnt = '0;
            n.sda_hold = 1'b0;
        end else begin
            case (q.state)
                S_ADDR, S_ADDR2, S_RX: begin
                    if (scl_rise) begin
                        n.shift = {q.shift[6:0], sda_s};
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
                        n.cnt = '0;
                        if (q.state == S_RX) begin
                            n.rx_data = q.shift;
                            ev[EV_RX] = 1'b1;
                            n.sda_hold = 1'b1;
                            n.state = S_RX_ACK;
                        end else if (q.state == S_ADDR2) begin
                            if (q.control[B_ACCEPT_ALL]
                                || q.shift == q.slave_addr[7:0]) begin
                                n.sda_hold = 1'b1;
                                n.wide_seen = 1'b1;
                                n.state = S_ADDR2_ACK;
                            end else begin
                                n.state = S_WAIT_STOP;
                            end
                        end else if (addr_hit) begin
                            n.sda_hold = 1'b1;
                            n.reading = q.shift[0] && !gc_hit;
                            ev[EV_GCALL] = gc_hit;
                            n.state = S_ADDR_ACK;
                        end else begin
                            n.state = S_WAIT_STOP;
                        end
                    end
                end
                S_ADDR_ACK: begin
                    if (scl_fall) begin
                        n.sda_hold = 1'b0;
                        if (q.reading) begin
                            ev[EV_ADDR] = 1'b1;
                            n.shift = q.tx_data;
                            n.sda_hold = !q.tx_data[7];
                            n.control[B_CLK_REL] = 1'b0;
                            n.state = S_TX;
                        end else if (q.control[B_WIDE]
                            && !q.control[B_ACCEPT_ALL]
                            && q.shift != GCALL_ADDR) begin
                            n.state = S_ADDR2;
                        end else begin
                            ev[EV_ADDR] = 1'b1;
                            n.control[B_CLK_REL] = 1'b0;
                            n.state = S_RX;
                        end
                    end
                end
                S_ADDR2_ACK: begin
                    if (scl_fall) begin
                        ev[EV_ADDR] = 1'b1;
                        n.sda_hold = 1'b0;
                        n.control[B_CLK_REL] = 1'b0;
                        n.state = S_RX;
                    end
                end
                S_RX_ACK: begin
                    if (scl_fall) begin
                        n.sda_hold = 1'b0;
                        if (q.control[B_STRETCH]) begin
                            n.control[B_CLK_REL] = 1'b0;
                        end
                        n.state = S_RX;
                    end
                end
                S_TX: begin
                    if (scl_rise) begin
                        n.cnt = q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.cnt == BITS_PER_BYTE) begin
                            n.sda_hold = 1'b0;
                            n.cnt = '0;
                            n.state = S_TX_ACK;
                        end else begin
                            n.sda_hold = !q.shift[6];
                            n.shift = {q.shift[6:0], 1'b0};
                        end
                    end
                end
                S_TX_ACK: begin
                    if (scl_rise) begin
                        ev[EV_TX] = 1'b1;
                        n.acked = !sda_s;
                    end else if (scl_fall) begin
                        if (q.acked) begin
                            n.shift = q.tx_data;
                            n.sda_hold = !q.tx_data[7];
                            if (q.control[B_STRETCH]) begin
                                n.control[B_CLK_REL] = 1'b0;
                            end
                            n.state = S_TX;
                        end else begin
                            n.state = S_WAIT_STOP;
                        end
                    end
                end
                S_WAIT_STOP: n.sda_hold = 1'b0;
                default: n.state = S_IDLE;
            endcase
        end
        n.status = n.status | ev;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
            q.control <= CONTROL_RESET;
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
            q.state <= S_IDLE;
        end else begin
            q <= n;
        end
    end

    always_comb begin
        if (q.control[B_MODULE_ON]) begin
            scl_pin.out = 1'b0;
            scl_pin.oe_n = !(run && busy && !q.control[B_CLK_REL]);
            sda_pin.out = 1'b0;
            sda_pin.oe_n = !(run && q.sda_hold);
        end else begin
            scl_pin = port_scl;
            sda_pin = port_sda;
        end
    end

    assign bus_rdata = q.rdata;
    assign master_go = q.go;
    assign slew_off = q.control[B_SLEW_OFF];
    assign smbus_levels = q.control[B_SMB_LEVELS];
    assign irq = |(q.status & q.enable);

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_first_byte_done;
        q.state == S_ADDR && scl_fall && q.cnt == BITS_PER_BYTE && run
            && !start_seen && !stop_seen;
    endsequence
    sequence s_rx_byte_acked;
        q.state == S_RX_ACK && scl_fall && run && !start_seen && !stop_seen;
    endsequence

    chk_port_owns_pins: assert property (
        !q.control[B_MODULE_ON] |-> scl_pin == port_scl
            && sda_pin == port_sda)
        else $error("pins not handed to port logic while off");
    chk_idle_halt_stops: assert property (
        q.control[B_MODULE_ON] && q.control[B_IDLE_HALT] && idle_mode
            |=> q.state == S_IDLE && sda_pin.oe_n)
        else $error("block kept running in idle with halt set");
    chk_release_frees_scl: assert property (
        q.control[B_MODULE_ON] && q.control[B_CLK_REL] |-> scl_pin.oe_n)
        else $error("clock line held while released");
    chk_accept_all_acks: assert property (
        s_first_byte_done and q.control[B_ACCEPT_ALL]
            |=> q.state == S_ADDR_ACK ##0 !sda_pin.oe_n)
        else $error("address not acknowledged in accept-all mode");
    chk_seven_bit_match: assert property (
        s_first_byte_done and !q.control[B_WIDE]
            && q.shift[7:1] == q.slave_addr[6:0] |=> q.state == S_ADDR_ACK)
        else $error("7-bit address match not acknowledged");
    chk_gcall_gated: assert property (
        $rose(q.status[EV_GCALL]) |-> $past(q.control[B_GC_EN])
            && $past(q.state) == S_ADDR)
        else $error("general call event without enable");
    chk_stretch_after_rx: assert property (
        s_rx_byte_acked and q.control[B_STRETCH]
            |=> !q.control[B_CLK_REL] && !scl_pin.oe_n)
        else $error("clock not stretched after received byte");
endmodule : icrl_core
`default_nettype wire

/* File: hdl/icrl_pkg.sv */
// constants, field layout and carrier types of the serial bus control block
// assumes one 100 MHz system clock and a synchronous active-high reset
package icrl_pkg;

    // register indices on the plain register port
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_SLAVE = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_RXDATA = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_TXDATA = 3'h6;

    // serial_bus_control field positions
    localparam int B_MODULE_ON = 15;
    localparam int B_IDLE_HALT = 13;
    localparam int B_CLK_REL = 12;
    localparam int B_ACCEPT_ALL = 11;
    localparam int B_WIDE = 10;
    localparam int B_SLEW_OFF = 9;
    localparam int B_SMB_LEVELS = 8;
    localparam int B_GC_EN = 7;
    localparam int B_STRETCH = 6;
    localparam int B_ACK_DATA = 5;
    localparam int GO_W = 5;
    localparam logic [15:0] CONTROL_RESET = 16'h1000;
    localparam logic [15:0] CONTROL_WMASK = 16'hbfff;
    localparam logic [15:0] MASTER_GO_MASK = 16'h001f;

    // slave_address_reg width and address patterns
    localparam int SADDR_W = 10;
    localparam logic [7:0] GCALL_ADDR = 8'h00;
    localparam logic [4:0] WIDE_PREFIX = 5'h1e;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // event bits of status, clear and enable registers
    localparam int NUM_EVENTS = 5;
    localparam int EV_ADDR = 0;
    localparam int EV_RX = 1;
    localparam int EV_TX = 2;
    localparam int EV_GCALL = 3;
    localparam int EV_STOP = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } icrl_bus_req_type;

    typedef struct packed {
        logic out;
        logic oe_n;
    } icrl_pin_type;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_ADDR2, S_ADDR2_ACK,
        S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_WAIT_STOP
    } icrl_state_type;

endpackage : icrl_pkg

/* File: hdl/icrl_sync.sv */
// two flip-flop synchroniser for pin levels
// assumes the inputs are asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module icrl_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import icrl_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } icrl_sync_state_type;

    icrl_sync_state_type q;
    icrl_sync_state_type d;

    always_comb begin
        d.meta = async_in;
        d.stable = q.meta;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.stable;
endmodule : icrl_sync
`default_nettype wire
